// >>> common/cfgtm_pkg.sv
// Package: register map, field positions and timing counts of the configuration block
package cfgtm_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  // Register index; the bus address is four times it
  localparam logic [11:0] CFG_ONE_INDEX   = 12'h01F;
  localparam logic [11:0] CFG_ONE_OFFSET  = {CFG_ONE_INDEX[9:0], 2'b00};
  localparam logic [11:0] STATUS_OFFSET   = 12'h004;
  // ----------------------------------------
  // Fields of system_config_one
  // ----------------------------------------
  localparam int          WATCHDOG_PERIOD_SELECT_BIT = 7;
  localparam int          LVD_KEEP_IN_STOP_BIT       = 6;
  localparam int          LVD_RESET_BLOCK_BIT        = 5;
  localparam int          LVD_POWER_OFF_BIT          = 4;
  localparam logic [7:0]  CFG_ONE_RESET              = 8'h00;
  // ----------------------------------------
  // Fields of the status register
  // ----------------------------------------
  localparam int          STAT_LVD_LEVEL_BIT  = 0;
  localparam int          STAT_LVD_ENABLE_BIT = 1;
  localparam int          STAT_STOP_BIT       = 2;
  localparam int          STAT_LOCKED_BIT     = 3;
  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int          TIMER_WIDTH        = 18;
  localparam int unsigned WDOG_SHORT_COUNT   = 8176;
  localparam int unsigned WDOG_LONG_COUNT    = 262128;
  localparam int unsigned WAKEUP_SHORT_COUNT = 512;
  localparam int unsigned WAKEUP_LONG_COUNT  = 16384;
endpackage

// >>> common/cfgtm_timer_if.sv
// Interface: control and expiry of one period timer
`timescale 1ns/100ps
interface cfgtm_timer_if;
  import cfgtm_pkg::*;
  logic                   clear;
  logic                   tick;
  logic [TIMER_WIDTH-1:0] limit;
  logic                   expire;
  modport timer (input clear, input tick, input limit, output expire);
  modport owner (output clear, output tick, output limit, input expire);
endinterface

// >>> hw/cfgtm_config_top.sv
// Configuration register with watchdog and auto-wakeup periods and detector control
// What this block does
// - Outside stop, select bit 1: watchdog reset after 8176 fast bus clocks.
// - Outside stop, select bit 0: watchdog reset after 262,128 fast bus clocks.
// - In stop, select bit 1: auto-wakeup after 512 RC oscillator periods.
// - In stop, select bit 0: auto-wakeup after 16,384 RC oscillator periods.
// - Detector not powered off: keep-in-stop bit decides if it runs in stop.
// - Every reset clears the keep-in-stop bit.
// - Reset-block bit 1 stops detector resets; 0 lets them through.
// - Reset-block bit is writable at any time.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module cfgtm_config_top #(
  parameter int unsigned WDOG_SHORT_CYC  = cfgtm_pkg::WDOG_SHORT_COUNT,
  parameter int unsigned WDOG_LONG_CYC   = cfgtm_pkg::WDOG_LONG_COUNT,
  parameter int unsigned WAKEUP_LONG_CYC = cfgtm_pkg::WAKEUP_LONG_COUNT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stopMode,
  input  wire logic        wdogKick,
  input  wire logic        internal_rc_oscillator,
  input  wire logic        lvdTrip,
  output logic             wdogResetReq,
  output logic             wakeupReq,
  output logic             lvdEnable,
  output logic             lvdResetReq
);
  import cfgtm_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  localparam logic [TIMER_WIDTH-1:0] WD_SHORT = TIMER_WIDTH'(WDOG_SHORT_CYC);
  localparam logic [TIMER_WIDTH-1:0] WD_LONG  = TIMER_WIDTH'(WDOG_LONG_CYC);
  localparam logic [TIMER_WIDTH-1:0] AW_SHORT = TIMER_WIDTH'(WAKEUP_SHORT_COUNT);
  localparam logic [TIMER_WIDTH-1:0] AW_LONG  = TIMER_WIDTH'(WAKEUP_LONG_CYC);

  function automatic logic [TIMER_WIDTH-1:0] pickLimit(input logic                   sel,
                                                      input logic [TIMER_WIDTH-1:0] shortLim,
                                                      input logic [TIMER_WIDTH-1:0] longLim);
    return sel ? shortLim : longLim;
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [7:0]  cfgQ;
  logic        lockedQ;
  logic        accessPhase;
  logic        cfgWrite;
  logic        hitCfg;
  logic        hitStat;
  logic [31:0] readMux;
  logic        rcLevelQ;
  logic        lvdLevelQ;
  logic        periodSel;

  assign accessPhase = psel && penable;
  assign hitCfg      = (paddr == CFG_ONE_OFFSET);
  assign hitStat     = (paddr == STATUS_OFFSET);
  assign cfgWrite    = accessPhase && pready && pwrite && hitCfg;
  assign periodSel   = cfgQ[WATCHDOG_PERIOD_SELECT_BIT];

  always_comb begin
    readMux = 32'h00000000;
    if (hitCfg) begin
      readMux[7:0] = cfgQ;
    end else if (hitStat) begin
      readMux[STAT_LVD_LEVEL_BIT]  = lvdLevelQ;
      readMux[STAT_LVD_ENABLE_BIT] = lvdEnable;
      readMux[STAT_STOP_BIT]       = stopMode;
      readMux[STAT_LOCKED_BIT]     = lockedQ;
    end
  end

  // One wait state: answer comes on the second access cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (accessPhase && !pready) begin
      pready  <= 1'b1;
      pslverr <= !(hitCfg || hitStat);
      prdata  <= pwrite ? 32'h00000000 : readMux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfgQ    <= CFG_ONE_RESET;
      lockedQ <= 1'b0;
    end else if (cfgWrite) begin
      cfgQ[LVD_RESET_BLOCK_BIT] <= pwdata[LVD_RESET_BLOCK_BIT];
      if (!lockedQ) begin
        cfgQ    <= pwdata[7:0];
        lockedQ <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers, three stages each
  // ----------------------------------------
  logic [2:0] rcSyncQ;
  logic [2:0] lvdSyncQ;
  logic       rcEdge;

  // A level is accepted only when stages two and three agree
  assign rcEdge = (rcSyncQ[1] == rcSyncQ[2]) && rcSyncQ[2] && !rcLevelQ;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rcSyncQ  <= 3'h0;
      rcLevelQ <= 1'b0;
    end else begin
      rcSyncQ <= {rcSyncQ[1:0], internal_rc_oscillator};
      if (rcSyncQ[1] == rcSyncQ[2]) begin
        rcLevelQ <= rcSyncQ[2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lvdSyncQ  <= 3'h0;
      lvdLevelQ <= 1'b0;
    end else begin
      lvdSyncQ <= {lvdSyncQ[1:0], lvdTrip};
      if (lvdSyncQ[1] == lvdSyncQ[2]) begin
        lvdLevelQ <= lvdSyncQ[2];
      end
    end
  end

  // ----------------------------------------
  // Watchdog and auto-wakeup timers
  // ----------------------------------------
  cfgtm_timer_if wdT ();
  cfgtm_timer_if awT ();

  // Each clk_sys cycle stands for one period of the fast bus clock
  assign wdT.tick  = !stopMode;
  assign wdT.clear = wdogKick || stopMode || cfgWrite;
  assign wdT.limit = pickLimit(periodSel, WD_SHORT, WD_LONG);
  assign awT.tick  = stopMode && rcEdge;
  assign awT.clear = !stopMode || cfgWrite;
  assign awT.limit = pickLimit(periodSel, AW_SHORT, AW_LONG);

  cfgtm_period_timer uWdTimer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tmr     (wdT)
  );

  cfgtm_period_timer uAwTimer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tmr     (awT)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wdogResetReq <= 1'b0;
      wakeupReq    <= 1'b0;
    end else begin
      wdogResetReq <= wdT.expire;
      wakeupReq    <= awT.expire;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lvdEnable   <= 1'b0;
      lvdResetReq <= 1'b0;
    end else begin
      lvdEnable   <= !cfgQ[LVD_POWER_OFF_BIT] && (!stopMode || cfgQ[LVD_KEEP_IN_STOP_BIT]);
      lvdResetReq <= lvdLevelQ && !cfgQ[LVD_RESET_BLOCK_BIT];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [TIMER_WIDTH-1:0] aWdCntQ;
  logic [TIMER_WIDTH-1:0] aAwCntQ;
  logic                   aFirstQ;

  // Independent tick counters, never cleared by expiry checks themselves
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aWdCntQ <= '0;
      aAwCntQ <= '0;
      aFirstQ <= 1'b1;
    end else begin
      aFirstQ <= 1'b0;
      aWdCntQ <= (wdT.clear || wdT.expire) ? '0 : aWdCntQ + TIMER_WIDTH'(wdT.tick);
      aAwCntQ <= (awT.clear || awT.expire) ? '0 : aAwCntQ + TIMER_WIDTH'(awT.tick);
    end
  end

  property p_wd_short;
    wdT.expire && periodSel |-> (aWdCntQ == WD_SHORT - 18'h00001) ##1 wdogResetReq;
  endproperty
  a_wd_short: assert property (p_wd_short) else $error("Short watchdog period wrong");

  property p_wd_long;
    wdT.expire && !periodSel |-> (aWdCntQ == WD_LONG - 18'h00001) ##1 wdogResetReq;
  endproperty
  a_wd_long: assert property (p_wd_long) else $error("Long watchdog period wrong");

  property p_aw_short;
    awT.tick && periodSel && !awT.clear && aAwCntQ == AW_SHORT - 18'h00001 |-> ##1 wakeupReq;
  endproperty
  a_aw_short: assert property (p_aw_short) else $error("Short wakeup period missed");

  property p_aw_long;
    wakeupReq && !$past(periodSel) |-> $past(aAwCntQ) == AW_LONG - 18'h00001;
  endproperty
  a_aw_long: assert property (p_aw_long) else $error("Long wakeup period wrong");

  property p_lvd_stop;
    stopMode && !cfgQ[LVD_POWER_OFF_BIT] |-> ##1 (lvdEnable == $past(cfgQ[LVD_KEEP_IN_STOP_BIT]));
  endproperty
  a_lvd_stop: assert property (p_lvd_stop) else $error("Detector stop enable wrong");

  property p_reset_clear;
    aFirstQ |-> !cfgQ[LVD_KEEP_IN_STOP_BIT] && !lvdEnable;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Keep-in-stop not cleared");

  property p_lvd_block;
    lvdLevelQ && cfgQ[LVD_RESET_BLOCK_BIT] && !cfgWrite [*2] |-> !lvdResetReq;
  endproperty
  a_lvd_block: assert property (p_lvd_block) else $error("Blocked detector reset passed");

  property p_lvd_pass;
    lvdLevelQ && !cfgQ[LVD_RESET_BLOCK_BIT] |-> ##1 lvdResetReq;
  endproperty
  a_lvd_pass: assert property (p_lvd_pass) else $error("Detector reset lost");

  property p_block_any_time;
    cfgWrite && lockedQ |-> ##1 cfgQ[LVD_RESET_BLOCK_BIT] == $past(pwdata[LVD_RESET_BLOCK_BIT]);
  endproperty
  a_block_any_time: assert property (p_block_any_time) else $error("Reset-block write lost");

  property p_write_once;
    lockedQ |-> ##1 (cfgQ & 8'hDF) == ($past(cfgQ) & 8'hDF);
  endproperty
  a_write_once: assert property (p_write_once) else $error("Locked bits changed");

  c_wd_fire:   cover property (wdogResetReq);
  c_wake_fire: cover property (wakeupReq);
  c_late_wr:   cover property (cfgWrite && lockedQ);
  c_lvd_rst:   cover property (lvdResetReq);
endmodule

// >>> hw/cfgtm_period_timer.sv
// Period timer: counts ticks and pulses expire on the last tick of a period
`timescale 1ns/100ps
module cfgtm_period_timer (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  cfgtm_timer_if.timer    tmr
);
  import cfgtm_pkg::*;

  logic [TIMER_WIDTH-1:0] countQ;
  logic                   lastTick;

  assign lastTick   = tmr.tick && (countQ == tmr.limit - 18'h00001);
  assign tmr.expire = lastTick && !tmr.clear;

  // Restarts after expiry so the period repeats while nobody clears it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      countQ <= '0;
    end else if (tmr.clear || lastTick) begin
      countQ <= '0;
    end else if (tmr.tick) begin
      countQ <= countQ + 18'h00001;
    end
  end
endmodule

// >>> tb/cfgtm_config_top_tb.sv
// Testbench: configuration register, timer periods and detector control
`timescale 1ns/100ps
module cfgtm_config_top_tb;
  import cfgtm_pkg::*;
  // ----------------------------------------
  // Shortened counts, short wakeup stays fixed
  // ----------------------------------------
  localparam int unsigned WD_SHORT = 20;
  localparam int unsigned WD_LONG  = 40;
  localparam int unsigned WK_LONG  = 8;
  localparam int unsigned WK_SHORT = 512;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stopMode = 1'b0;
  logic        wdogKick = 1'b0;
  logic        rcOsc    = 1'b0;
  logic        lvdTrip  = 1'b0;
  logic        wdogResetReq, wakeupReq, lvdEnable, lvdResetReq;
  int          fail_count = 0;
  int          compares   = 0;
  int          cycles     = 0;

  cfgtm_config_top #(.WDOG_SHORT_CYC(WD_SHORT), .WDOG_LONG_CYC(WD_LONG), .WAKEUP_LONG_CYC(WK_LONG)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stopMode(stopMode),
    .wdogKick(wdogKick), .internal_rc_oscillator(rcOsc), .lvdTrip(lvdTrip), .wdogResetReq(wdogResetReq),
    .wakeupReq(wakeupReq), .lvdEnable(lvdEnable), .lvdResetReq(lvdResetReq));

  always #50 clk_sys = ~clk_sys;
  // Hang guard, well above the longest expected run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    compares++;
    if (got !== expv) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic reset_dut();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] expv,
                     input logic expErr);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Ends when pready is sampled high; only the hang guard ends it if pready never comes
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    if (!wr) chk("prdata", expv, prdata);
    chk("pslverr", {31'h0, expErr}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_wdog(input int unsigned n);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wdogResetReq !== 1'b1 && k < 2 * n + 10);
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wdogResetReq !== 1'b1 && k < 2 * n + 10);
    chk("watchdog period", n, k);
    // Kicks spaced under the period must hold the reset off
    for (int i = 0; i < 4; i++) begin
      repeat (n - 4) begin
        @(posedge clk_sys);
        chk("watchdog after kick", 32'h0, {31'h0, wdogResetReq});
      end
      wdogKick <= 1'b1;
      @(posedge clk_sys);
      wdogKick <= 1'b0;
    end
  endtask
  task automatic test_wakeup(input int unsigned n);
    int  e;
    logic seen;
    e = 0;
    seen = 1'b0;
    stopMode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    while (!seen && e < n + 4) begin
      rcOsc <= 1'b1;
      e++;
      repeat (4) begin
        @(posedge clk_sys);
        if (wakeupReq === 1'b1) seen = 1'b1;
      end
      rcOsc <= 1'b0;
      repeat (4) begin
        @(posedge clk_sys);
        if (wakeupReq === 1'b1) seen = 1'b1;
      end
    end
    chk("wakeup edge count", n, e);
    stopMode <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic test_detector(input logic enStop, input logic enRun, input logic rstExp);
    stopMode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("lvdEnable in stop", {31'h0, enStop}, {31'h0, lvdEnable});
    stopMode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("lvdEnable in run", {31'h0, enRun}, {31'h0, lvdEnable});
    lvdTrip <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("lvdResetReq on trip", {31'h0, rstExp}, {31'h0, lvdResetReq});
    lvdTrip <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("lvdResetReq idle", 32'h0, {31'h0, lvdResetReq});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_dut();
    apb(1'b0, CFG_ONE_OFFSET, 32'h0, 32'h00000000, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0, 32'h00000002, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h00000000, 1'b1);
    apb(1'b1, 12'h00C, 32'h000000FF, 32'h0, 1'b1);
    test_wdog(WD_LONG);
    test_wakeup(WK_LONG);
    test_detector(1'b0, 1'b1, 1'b1);
    // First write locks every bit but the reset block
    apb(1'b1, CFG_ONE_OFFSET, 32'h000000E0, 32'h0, 1'b0);
    apb(1'b0, CFG_ONE_OFFSET, 32'h0, 32'h000000E0, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0, 32'h0000000A, 1'b0);
    test_wdog(WD_SHORT);
    test_wakeup(WK_SHORT);
    test_detector(1'b1, 1'b1, 1'b0);
    apb(1'b1, CFG_ONE_OFFSET, 32'h00000000, 32'h0, 1'b0);
    apb(1'b0, CFG_ONE_OFFSET, 32'h0, 32'h000000C0, 1'b0);
    test_detector(1'b1, 1'b1, 1'b1);
    reset_dut();
    apb(1'b0, CFG_ONE_OFFSET, 32'h0, 32'h00000000, 1'b0);
    apb(1'b1, CFG_ONE_OFFSET, 32'h00000050, 32'h0, 1'b0);
    test_detector(1'b0, 1'b0, 1'b1);
    conclude();
  end
endmodule
